// [design/afesp_pkg.sv]
// Purpose: Shared constants and types for the converter front-end serial port.
// Assumes: Register data is 24 bits wide; the port logic runs on the reference clock.
// Notes: Status field positions and the status register index are local choices.
package afesp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned REG_CNT = 32;
  localparam int unsigned REG_W = 24;
  localparam logic [4:0] ADC_LAST = 5'h07;
  localparam logic [4:0] CFG_FIRST = 5'h08;
  localparam logic [4:0] MOD_ADDR = 5'h08;
  localparam logic [4:0] STATUS_ADDR = 5'h0c;
  localparam logic [4:0] LOCK_ADDR = 5'h1f;
  localparam logic [4:0] LAST_ADDR = 5'h1f;

  // ----------------------------------------------------------------
  // Status/communication register fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_READ_LSB = 22;
  localparam int unsigned STAT_WRITE_BIT = 21;
  localparam int unsigned STAT_WIDTH_LSB = 19;
  localparam int unsigned STAT_CRC_EN_BIT = 18;
  localparam int unsigned STAT_CRC_IRQ_BIT = 17;
  localparam logic [23:0] STATUS_RST = 24'ha80000;
  localparam logic [7:0] DRSTAT_RST = 8'hff;

  // ----------------------------------------------------------------
  // Lock key and checksum
  // ----------------------------------------------------------------
  localparam int unsigned LOCK_LSB = 16;
  localparam logic [7:0] LOCK_KEY = 8'ha5;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // ----------------------------------------------------------------
  // Control byte and data formats
  // ----------------------------------------------------------------
  localparam logic [1:0] DEV_ADDR = 2'b01;
  localparam logic [5:0] CMD_LAST_BIT = 6'h07;
  localparam logic [1:0] FMT_16 = 2'b00;
  localparam logic [1:0] FMT_24 = 2'b01;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_32 = 6'h20;
  localparam logic [1:0] RD_STATIC = 2'b00;
  localparam logic [1:0] RD_GROUPS = 2'b01;
  localparam logic [1:0] RD_TYPES = 2'b10;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_NS = 100;
  localparam int unsigned DR_PULSE_NS = 100;
  localparam logic [3:0] DR_PULSE_CYC = 4'((DR_PULSE_NS + REF_CLK_NS - 1) / REF_CLK_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] chan;
    logic [23:0] data;
  } afesp_adc_word_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_IGNORE = 3'b100
  } afesp_state_t;

endpackage : afesp_pkg

// [design/afesp_fifo2.sv]
// Purpose: Small FIFO that holds converter words until the port is free.
// Assumes: Single clock; both sides use valid and ready.
// Notes: Input ready is registered so the top level can drive it straight out.
`timescale 1ns/1ps
module afesp_fifo2 #(
  parameter int unsigned DEPTH = 2,
  parameter int unsigned WIDTH = 27
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Fill side
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  // Drain side
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic push, pop;

  assign push = i_in_valid & rdy_r;
  assign pop = (cnt_r != '0) & i_out_ready;
  assign o_in_ready = rdy_r;
  assign o_out_valid = cnt_r != '0;
  assign o_out_data = mem_r[rp_r];

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == LAST_PTR) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == LAST_PTR) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    rdy_nxt = cnt_nxt != FULL_CNT;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // Storage has no reset; an entry is only read after it was written.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

endmodule : afesp_fifo2

// [design/afesp_top.sv]
// Purpose: Four-wire serial slave port with register map, lock and checksums.
// Assumes: Serial pins are asynchronous and sampled by the reference clock.
// Notes: The serial clock must stay well below a quarter of the reference clock.
//
// Behaviour
// - Drive output on falling, sample on rising
// - Work with clock idling low or high
// - Port logic runs on the reference clock; pin crossings synchronised
// - Chip select frames each independent transaction
// - Deselected: output released, clock and data ignored
// - Chip select rise aborts, state machine idles
// - Pulse data ready on new converter data
// - Hard reset restores power-up register state
// - Control byte then 16/24/32-bit register data
// - Thirty-two registers, each command reads or writes
// - Address advances automatically within the looping set
// - Optional checksum appended after each read sequence
// - Writes other than to the key register rejected unless key equals the password
// - Background checksum over writable configuration registers; registers 0x08 and 0x1f are left out
// - Checksum change drives data ready low
// - Control byte: device address, index, direction
// - Output released during the control byte
// - Respond only to own device address
// - Locked: only the key register is writable
// - Non-writable write ignored, pointer does not advance
// - Read loop: static, groups, types, full
// - Pointer wraps to set start until deselect
`timescale 1ns/1ps
module afesp_top (
  // Clock and hard reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe,
  // Converter data stream
  input wire afesp_pkg::afesp_adc_word_t i_adc_word,
  input wire logic i_adc_valid,
  output logic o_adc_ready,
  // Host interrupt
  output logic o_data_ready_n
);
  import afesp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic cs_s1_r, cs_s2_r, sck_s1_r, sck_s2_r, sck_s3_r, sdi_s1_r, sdi_s2_r;
  logic sck_rise, sck_fall, in_frame;

  // Two stages before any logic reads a pin; sck keeps a third for edges.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= i_cs_n;
      cs_s2_r <= cs_s1_r;
      sck_s1_r <= i_sck;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      sdi_s1_r <= i_sdi;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  // Edges are found independently of the idle level, so both modes work.
  assign in_frame = !cs_s2_r;
  assign sck_rise = in_frame && sck_s2_r && !sck_s3_r;
  assign sck_fall = in_frame && !sck_s2_r && sck_s3_r;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : crc_step

  // Returns {end of set, next address} for a looping mode.
  function automatic logic [5:0] next_addr(input logic [4:0] a, input logic [1:0] m);
    logic w;
    w = 1'b0;
    case (m)
      RD_STATIC: next_addr = {1'b1, a};
      RD_GROUPS: next_addr = {a[1:0] == 2'b11, a[4:2], a[1:0] + 2'b01};
      RD_TYPES: begin
        if (a <= ADC_LAST) begin
          w = a == ADC_LAST;
          next_addr = {w, w ? 5'h00 : a + 5'h01};
        end else begin
          w = a == LAST_ADDR;
          next_addr = {w, w ? CFG_FIRST : a + 5'h01};
        end
      end
      default: next_addr = {a == LAST_ADDR, a + 5'h01};
    endcase
  endfunction : next_addr

  function automatic logic [5:0] fmt_len(input logic [1:0] f);
    case (f)
      FMT_16: fmt_len = LEN_16;
      FMT_24: fmt_len = LEN_24;
      default: fmt_len = LEN_32;
    endcase
  endfunction : fmt_len

  // Words are left aligned in the shifter so the top bit always leaves first.
  function automatic logic [31:0] fmt_word(input logic [23:0] w, input logic [1:0] f);
    case (f)
      FMT_16: fmt_word = {w[23:8], 16'h0000};
      FMT_24: fmt_word = {w, 8'h00};
      default: fmt_word = {{8{w[23]}}, w};
    endcase
  endfunction : fmt_word

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [REG_W-1:0] regs_r [REG_CNT];
  afesp_state_t state_r, state_nxt;
  logic [5:0] bitc_r, bitc_nxt, len_r, len_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic [31:0] rx_r, rx_nxt, tx_r, tx_nxt;
  logic [15:0] rcrc_r, rcrc_nxt;
  logic crcw_r, crcw_nxt, sdo_r, sdo_nxt, oe_r, oe_nxt;
  logic [7:0] drstat_r, drstat_nxt;
  logic [3:0] drcnt_r, drcnt_nxt;
  logic alarm_r, alarm_nxt, drn_r, drn_nxt;
  logic we;
  logic [4:0] wa;
  logic [23:0] wd;
  logic ld;
  logic [4:0] ld_a;
  logic [23:0] ld_w;
  logic [7:0] ctrl;
  logic [5:0] na;
  logic [1:0] fmt, rd_mode;
  logic lock_open, crc_en, alarm_set;
  logic [23:0] status_w;
  afesp_adc_word_t fifo_word;
  logic fifo_valid, fifo_ready;
  logic [4:0] cfga_r, cfga_nxt, cfgb_r, cfgb_nxt;
  logic [15:0] cfgacc_r, cfgacc_nxt, cfgcrc_r, cfgcrc_nxt;
  logic cfgval_r, cfgval_nxt, skip;

  assign status_w = regs_r[STATUS_ADDR];
  assign fmt = status_w[STAT_WIDTH_LSB +: 2];
  assign rd_mode = status_w[STAT_READ_LSB +: 2];
  assign crc_en = status_w[STAT_CRC_EN_BIT];
  assign lock_open = regs_r[LOCK_ADDR][LOCK_LSB +: 8] == LOCK_KEY;

  // ----------------------------------------------------------------
  // Converter data buffer
  // ----------------------------------------------------------------
  // Words wait here while a transaction is open, so the map never changes mid-frame.
  afesp_fifo2 #(
    .DEPTH(2),
    .WIDTH($bits(afesp_adc_word_t))
  ) u_fifo (
    .i_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_in_data(i_adc_word),
    .i_in_valid(i_adc_valid),
    .o_in_ready(o_adc_ready),
    .o_out_data(fifo_word),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready)
  );
  // Pop only where the map write happens, so no word is dropped at a frame start.
  assign fifo_ready = !in_frame;

  // ----------------------------------------------------------------
  // Transaction state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    bitc_nxt = bitc_r;
    len_nxt = len_r;
    addr_nxt = addr_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    rcrc_nxt = rcrc_r;
    crcw_nxt = crcw_r;
    sdo_nxt = sdo_r;
    drstat_nxt = drstat_r;
    drcnt_nxt = (drcnt_r != 4'h0) ? drcnt_r - 4'h1 : 4'h0;
    alarm_nxt = alarm_r;
    we = 1'b0;
    wa = addr_r;
    wd = rx_r[23:0];
    ld = 1'b0;
    ld_a = addr_r;
    ld_w = 24'h000000;
    ctrl = {rx_r[6:0], sdi_s2_r};
    na = 6'h00;
    if (!in_frame) begin
      state_nxt = ST_IDLE;
      bitc_nxt = 6'h00;
      crcw_nxt = 1'b0;
      rcrc_nxt = CRC_INIT;
      if (fifo_valid) begin
        we = 1'b1;
        wa = {2'b00, fifo_word.chan};
        wd = fifo_word.data;
        drstat_nxt[fifo_word.chan] = 1'b0;
        drcnt_nxt = DR_PULSE_CYC;
      end
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = ST_CMD;
          bitc_nxt = 6'h00;
        end
        ST_CMD: begin
          if (sck_rise) begin
            rx_nxt = {rx_r[30:0], sdi_s2_r};
            bitc_nxt = bitc_r + 6'h01;
            if (bitc_r == CMD_LAST_BIT) begin
              bitc_nxt = 6'h00;
              addr_nxt = ctrl[5:1];
              len_nxt = fmt_len(fmt);
              if (ctrl[7:6] != DEV_ADDR) begin
                state_nxt = ST_IGNORE;
              end else if (ctrl[0]) begin
                state_nxt = ST_READ;
                ld = 1'b1;
                ld_a = ctrl[5:1];
              end else begin
                state_nxt = ST_WRITE;
              end
            end
          end
        end
        ST_READ: begin
          if (sck_fall) begin
            sdo_nxt = tx_r[31];
            tx_nxt = {tx_r[30:0], 1'b0};
            if (!crcw_r) begin
              rcrc_nxt = crc_step(rcrc_r, tx_r[31]);
            end
          end
          if (sck_rise) begin
            bitc_nxt = bitc_r + 6'h01;
            if (bitc_r == len_r - 6'h01) begin
              bitc_nxt = 6'h00;
              len_nxt = fmt_len(fmt);
              if (crcw_r) begin
                crcw_nxt = 1'b0;
                rcrc_nxt = CRC_INIT;
                ld = 1'b1;
              end else begin
                na = next_addr(addr_r, rd_mode);
                addr_nxt = na[4:0];
                ld_a = na[4:0];
                if (na[5] && crc_en) begin
                  tx_nxt = {rcrc_r, 16'h0000};
                  len_nxt = LEN_16;
                  crcw_nxt = 1'b1;
                end else begin
                  ld = 1'b1;
                end
              end
            end
          end
        end
        ST_WRITE: begin
          if (sck_rise) begin
            rx_nxt = {rx_r[30:0], sdi_s2_r};
            bitc_nxt = bitc_r + 6'h01;
            if (bitc_r == len_r - 6'h01) begin
              bitc_nxt = 6'h00;
              wd = (len_r == LEN_16) ? {rx_r[14:0], sdi_s2_r, 8'h00} :
                   {rx_r[22:0], sdi_s2_r};
              if (lock_open ? (addr_r >= CFG_FIRST) : (addr_r == LOCK_ADDR)) begin
                we = 1'b1;
                na = next_addr(addr_r, status_w[STAT_WRITE_BIT] ? RD_TYPES : RD_STATIC);
                addr_nxt = na[4:0];
              end
            end
          end
        end
        ST_IGNORE: begin
          state_nxt = ST_IGNORE;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
    if (ld) begin
      ld_w = regs_r[ld_a];
      if (ld_a == STATUS_ADDR) begin
        ld_w = {status_w[23:8], drstat_r};
        drstat_nxt = DRSTAT_RST;
        alarm_nxt = 1'b0;
      end else if (ld_a == LOCK_ADDR) begin
        ld_w = {regs_r[LOCK_ADDR][LOCK_LSB +: 8], cfgcrc_r};
      end
      tx_nxt = fmt_word(ld_w, fmt);
    end
    // A checksum change in the same cycle as a status read is not lost.
    if (alarm_set) begin
      alarm_nxt = 1'b1;
    end
    oe_nxt = in_frame && (state_nxt == ST_READ);
    drn_nxt = !((drcnt_nxt != 4'h0) || (alarm_nxt && status_w[STAT_CRC_IRQ_BIT]));
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      bitc_r <= 6'h00;
      len_r <= LEN_24;
      addr_r <= 5'h00;
      rx_r <= 32'h00000000;
      tx_r <= 32'h00000000;
      rcrc_r <= CRC_INIT;
      crcw_r <= 1'b0;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      drstat_r <= DRSTAT_RST;
      drcnt_r <= 4'h0;
      alarm_r <= 1'b0;
      drn_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      bitc_r <= bitc_nxt;
      len_r <= len_nxt;
      addr_r <= addr_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      rcrc_r <= rcrc_nxt;
      crcw_r <= crcw_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      drstat_r <= drstat_nxt;
      drcnt_r <= drcnt_nxt;
      alarm_r <= alarm_nxt;
      drn_r <= drn_nxt;
    end
  end

  // Hard reset returns the whole map to its power-up contents.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < REG_CNT; i++) begin
        regs_r[i] <= (5'(i) == STATUS_ADDR) ? STATUS_RST : 24'h000000;
      end
    end else if (we) begin
      regs_r[wa] <= wd;
    end
  end

  assign o_sdo = sdo_r;
  assign o_sdo_oe = oe_r;
  assign o_data_ready_n = drn_r;

  // ----------------------------------------------------------------
  // Background configuration checksum
  // ----------------------------------------------------------------
  // One bit per cycle keeps the engine tiny; a sweep takes a few hundred cycles.

  always_comb begin
    cfga_nxt = cfga_r;
    cfgb_nxt = cfgb_r + 5'h01;
    cfgacc_nxt = cfgacc_r;
    cfgcrc_nxt = cfgcrc_r;
    cfgval_nxt = cfgval_r;
    alarm_set = 1'b0;
    skip = (cfga_r < CFG_FIRST) || (cfga_r == MOD_ADDR) || (cfga_r == LOCK_ADDR);
    if (skip) begin
      cfgb_nxt = 5'h00;
      cfga_nxt = cfga_r + 5'h01;
      if (cfga_r == LAST_ADDR) begin
        cfgcrc_nxt = cfgacc_r;
        cfgacc_nxt = CRC_INIT;
        cfgval_nxt = 1'b1;
        alarm_set = cfgval_r && (cfgacc_r != cfgcrc_r);
      end
    end else begin
      cfgacc_nxt = crc_step(cfgacc_r, regs_r[cfga_r][5'd23 - cfgb_r]);
      if (cfgb_r == 5'd23) begin
        cfgb_nxt = 5'h00;
        cfga_nxt = cfga_r + 5'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfga_r <= 5'h00;
      cfgb_r <= 5'h00;
      cfgacc_r <= CRC_INIT;
      cfgcrc_r <= CRC_INIT;
      cfgval_r <= 1'b0;
    end else begin
      cfga_r <= cfga_nxt;
      cfgb_r <= cfgb_nxt;
      cfgacc_r <= cfgacc_nxt;
      cfgcrc_r <= cfgcrc_nxt;
      cfgval_r <= cfgval_nxt;
    end
  end

endmodule : afesp_top

// [tb/afesp_checker.sv]
// Purpose: Pin-level checks on the serial port and converter stream.
// Assumes: Serial half period of at least four reference clocks.
// Notes: The control byte is rebuilt here from the pins.
`timescale 1ns/1ps
module afesp_checker (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic o_sdo,
  input wire logic o_sdo_oe,
  // Converter stream
  input wire afesp_pkg::afesp_adc_word_t i_adc_word,
  input wire logic i_adc_valid,
  input wire logic o_adc_ready,
  input wire logic o_data_ready_n
);
  import afesp_pkg::*;
  logic sck_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Pin edges count at once; the design sees them a few clocks later.
  always_comb begin
    cnt_nxt = cnt_r;
    ctl_nxt = ctl_r;
    if (i_cs_n) begin
      cnt_nxt = 4'h0;
    end else if (i_sck && !sck_r && cnt_r != 4'h8) begin
      cnt_nxt = cnt_r + 4'h1;
      ctl_nxt = {ctl_r[6:0], i_sdi};
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sck_r <= 1'b0;
      cnt_r <= 4'h0;
      ctl_r <= 8'h00;
    end else begin
      sck_r <= i_sck;
      cnt_r <= cnt_nxt;
      ctl_r <= ctl_nxt;
    end
  end
  sequence s_accept;
    i_adc_valid && o_adc_ready && i_cs_n;
  endsequence
  sequence s_quiet;
    i_cs_n [*8];
  endsequence
  property p_rst;
    disable iff (1'b0) !i_nrst |-> !o_sdo_oe && o_data_ready_n && !o_adc_ready;
  endproperty
  a_rst: assert property (p_rst) else $error("output active in reset");
  property p_rel;
    $rose(i_nrst) |=> o_adc_ready;
  endproperty
  a_rel: assert property (p_rel) else $error("no ready after reset");
  property p_desel;
    s_quiet |-> !o_sdo_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("sdo driven while idle");
  property p_oe_ctl;
    $rose(o_sdo_oe) |-> cnt_r == 4'h8 && ctl_r[7:6] == DEV_ADDR && ctl_r[0];
  endproperty
  a_oe_ctl: assert property (p_oe_ctl) else $error("bad drive start");
  property p_abort;
    $rose(i_cs_n) |-> ##[1:8] !o_sdo_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("drive after deselect");
  property p_sdo;
    o_sdo_oe && $past(o_sdo_oe, 3) && $changed(o_sdo)
      |-> !$past(i_sck) && !$past(i_sck, 2) && !$past(i_sck, 3);
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo moved off falling edge");
  property p_dr;
    s_accept |-> ##[1:8] !o_data_ready_n;
  endproperty
  a_dr: assert property (p_dr) else $error("no data ready pulse");
  property p_drain;
    s_quiet |-> o_adc_ready;
  endproperty
  a_drain: assert property (p_drain) else $error("buffer not drained");
endmodule : afesp_checker

// [tb/afesp_host.sv]
// Purpose: Host serial master model for the front-end port.
// Assumes: The reference clock paces every serial edge.
// Notes: Each serial half period is four reference clocks.
`timescale 1ns/1ps
module afesp_host (
  // Clock
  input wire logic i_clk,
  // Bench controls
  input wire logic i_mode11,
  input wire logic i_hold,
  // Serial pins
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi
);
  logic cs_r = 1'b1;
  logic last = 1'b0;
  logic oe_seen = 1'b0;
  logic [95:0] rx = '0;
  assign o_cs_n = cs_r & ~i_hold;
  initial o_sdi = 1'b0;
  initial o_sck = 1'b0;
  // The idle level may follow the mode only while deselected.
  always @(negedge i_clk) if (cs_r && !i_hold) o_sck = i_mode11;
  // A released line reads as the inverse of the last bit, so stale data never match.
  task automatic xfer(input logic [7:0] ctl, input logic [95:0] wd, input int n);
    logic b;
    @(negedge i_clk);
    cs_r = 1'b0;
    oe_seen = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int i = 0; i < 8 + n; i++) begin
      o_sck = 1'b0;
      o_sdi = (i < 8) ? ctl[7 - i] : wd[n + 7 - i];
      repeat (4) @(negedge i_clk);
      b = i_sdo_oe ? i_sdo : ~last;
      last = b;
      oe_seen = oe_seen | i_sdo_oe;
      rx = {rx[94:0], b};
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
    end
    o_sck = i_mode11;
    repeat (4) @(negedge i_clk);
    cs_r = 1'b1;
    o_sdi = ~o_sdi;
    repeat (8) @(negedge i_clk);
  endtask : xfer
endmodule : afesp_host

// [tb/afesp_top_tb.sv]
// Purpose: Self-checking bench for the front-end serial port.
// Assumes: Host model paces frames; stream driven on falling clock edges.
// Notes: Expected words follow the register map choices of the design.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin \
  check_count++; \
  if ((s) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, s); \
  end \
end
module afesp_top_tb;
  import afesp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b1;
  logic mode11 = 1'b0;
  logic hold = 1'b0;
  logic adc_valid = 1'b0;
  afesp_adc_word_t adc_word = '0;
  logic cs_n, sck, sdi, sdo, sdo_oe, adc_ready, drdy_n;
  int fails = 0;
  int check_count = 0;
  wire [95:0] rx = afesp_host_i.rx;
  afesp_top afesp_top_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cs_n(cs_n),
    .i_sck(sck), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_adc_word(adc_word),
    .i_adc_valid(adc_valid), .o_adc_ready(adc_ready), .o_data_ready_n(drdy_n));
  afesp_host afesp_host_i (.i_clk(i_ref_clk), .i_mode11(mode11), .i_hold(hold),
    .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi));
  initial forever #50 i_ref_clk = ~i_ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : cyc
  task automatic wr(input logic [4:0] a, input logic [95:0] d, input int n);
    afesp_host_i.xfer({DEV_ADDR, a, 1'b0}, d, n);
  endtask : wr
  task automatic rd(input logic [4:0] a, input int n);
    afesp_host_i.xfer({DEV_ADDR, a, 1'b1}, 96'h0, n);
  endtask : rd
  task automatic push(input logic [2:0] c, input logic [23:0] d);
    int k;
    k = 0;
    adc_word = {c, d};
    adc_valid = 1'b1;
    while (adc_ready !== 1'b1 && k < 50) begin
      cyc(1);
      k++;
    end
    cyc(1);
    adc_valid = 1'b0;
    cyc(1);
  endtask : push
  function automatic logic [15:0] crc16(input logic [23:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0);
    end
    return c;
  endfunction : crc16
  task automatic note(input string s);
    $display("test %s done, checks %0d, fails %0d", s, check_count, fails);
  endtask : note
  task automatic final_report();
    $display("checks %0d, fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #1;
    i_nrst = 1'b0;
    cyc(1);
    `CHK("oe", 1'b0, sdo_oe)
    `CHK("drdy", 1'b1, drdy_n)
    cyc(15);
    i_nrst = 1'b1;
    cyc(4);
    rd(STATUS_ADDR, 24);
    `CHK("status", 24'ha800ff, rx[23:0])
    wr(5'h09, 24'h123456, 24);
    rd(5'h09, 24);
    `CHK("locked", 24'h0, rx[23:0])
    note("lock");
    wr(LOCK_ADDR, 24'ha50000, 24);
    mode11 = 1'b1;
    cyc(2);
    wr(5'h09, 24'h123456, 24);
    rd(5'h09, 24);
    `CHK("mode11", 24'h123456, rx[23:0])
    mode11 = 1'b0;
    cyc(2);
    wr(5'h07, 48'h111111222222, 48);
    rd(5'h08, 24);
    `CHK("ro", 24'h0, rx[23:0])
    wr(5'h1e, 48'habcdefa50000, 48);
    wr(5'h08, 24'h0f0f0f, 24);
    rd(5'h1e, 72);
    `CHK("cont", 24'habcdef, rx[71:48])
    `CHK("wrap", 24'h0f0f0f, rx[23:0])
    note("loop");
    wr(5'h09, 24'h654321, 12);
    rd(5'h09, 24);
    `CHK("abort", 24'h123456, rx[23:0])
    afesp_host_i.xfer({2'b10, 5'h09, 1'b0}, 96'h777777, 24);
    afesp_host_i.xfer({2'b00, 5'h09, 1'b1}, 96'h0, 24);
    `CHK("foreign oe", 1'b0, afesp_host_i.oe_seen)
    rd(5'h09, 24);
    `CHK("foreign wr", 24'h123456, rx[23:0])
    note("abort");
    wr(STATUS_ADDR, 24'h2c0000, 24);
    rd(5'h09, 40);
    `CHK("crc", {24'h123456, crc16(24'h123456)}, rx[39:0])
    wr(STATUS_ADDR, 24'ha00000, 24);
    rd(5'h09, 16);
    `CHK("w16", 16'h1234, rx[15:0])
    wr(STATUS_ADDR, 16'hb000, 16);
    rd(5'h09, 32);
    `CHK("w32", 32'h00123456, rx[31:0])
    note("format");
    push(3'h2, 24'habcdef);
    cyc(10);
    rd(5'h02, 32);
    `CHK("adc", 32'hffabcdef, rx[31:0])
    hold = 1'b1;
    cyc(8);
    push(3'h3, 24'h111111);
    push(3'h4, 24'h222222);
    adc_word = {3'h5, 24'h333333};
    adc_valid = 1'b1;
    cyc(4);
    `CHK("full", 1'b0, adc_ready)
    adc_valid = 1'b0;
    hold = 1'b0;
    cyc(10);
    rd(5'h04, 32);
    `CHK("held", 32'h00222222, rx[31:0])
    rd(5'h05, 32);
    `CHK("refused", 32'h0, rx[31:0])
    wr(STATUS_ADDR, 32'h00700000, 32);
    rd(5'h03, 64);
    `CHK("groups", 64'h0011111100000000, rx[63:0])
    note("stream");
    wr(LOCK_ADDR, 32'h0, 32);
    wr(5'h09, 32'h00999999, 32);
    rd(5'h09, 32);
    `CHK("relock", 32'h00123456, rx[31:0])
    note("relock");
    final_report();
  end
  // The sequence needs about ten thousand clocks; the limit allows three times that.
  initial begin
    #3000000;
    fails++;
    final_report();
  end
endmodule : afesp_top_tb
bind afesp_top afesp_checker afesp_checker_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
  .i_adc_word(i_adc_word), .i_adc_valid(i_adc_valid), .o_adc_ready(o_adc_ready),
  .o_data_ready_n(o_data_ready_n));
